//--- design/daod_decoder.sv
// Arithmetic opcode decoder, first group, for a 16-bit fixed-point core.
// Assumes fetch presents one word per valid cycle, in program order.
`timescale 1ns/1ps
module daod_decoder (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        word_valid_i,
  input  wire logic [15:0] word_i,
  output logic             dec_valid_o,
  output logic [4:0]       op_o,
  output logic [2:0]       words_o,
  output logic [2:0]       cycles_o,
  output logic             src_o,
  output logic             dst_o,
  output logic [7:0]       addr_o,
  output logic [3:0]       xmem_o,
  output logic [3:0]       ymem_o,
  output logic [5:0]       shift_o,
  output logic             illegal_o
);

  daod_pkg::daod_op_t    m_op;
  logic [1:0]            m_len;
  logic [1:0]            m_cyc;
  logic                  m_smem;

  daod_match u_match (
    .word_i (word_i),
    .op_o   (m_op),
    .len_o  (m_len),
    .cyc_o  (m_cyc),
    .smem_o (m_smem)
  );

  daod_pkg::daod_state_t state_q, state_d;
  logic [15:0]           first_q, first_d;
  logic [4:0]            op_q, op_d;
  logic [2:0]            words_q, words_d;
  logic [2:0]            cycles_q, cycles_d;
  logic                  src_q, src_d;
  logic                  dst_q, dst_d;
  logic [7:0]            addr_q, addr_d;
  logic [3:0]            xmem_q, xmem_d;
  logic [3:0]            ymem_q, ymem_d;
  logic [5:0]            shift_q, shift_d;
  logic                  valid_q, valid_d;
  logic                  ill_q, ill_d;
  logic [1:0]            skip_q, skip_d;

  // Long-offset indirect or absolute addressing in a single-memory operand.
  function automatic logic long_addr(input logic [7:0] a);
    long_addr = a[daod_pkg::ADDR_IND_BIT] &&
                (a[6:3] == daod_pkg::MOD_LONG_OFS ||
                 a[6:3] == daod_pkg::MOD_ABS);
  endfunction

  // Sign-extends a 4-bit shift to the 6-bit shift output.
  function automatic logic [5:0] sx4(input logic [3:0] s);
    sx4 = {{2{s[3]}}, s};
  endfunction

  always_comb begin
    state_d  = state_q;
    first_d  = first_q;
    op_d     = op_q;
    words_d  = words_q;
    cycles_d = cycles_q;
    src_d    = src_q;
    dst_d    = dst_q;
    addr_d   = addr_q;
    xmem_d   = xmem_q;
    ymem_d   = ymem_q;
    shift_d  = shift_q;
    valid_d  = 1'b0;
    ill_d    = 1'b0;
    skip_d   = skip_q;
    if (word_valid_i) begin
      unique case (state_q)
        daod_pkg::ST_FIRST: begin
          first_d  = word_i;
          op_d     = 5'(m_op);
          words_d  = {1'b0, m_len};
          cycles_d = {1'b0, m_cyc};
          src_d    = word_i[9];
          dst_d    = word_i[8];
          addr_d   = m_smem ? word_i[7:0] : 8'h00;
          xmem_d   = word_i[7:4];
          ymem_d   = word_i[3:0];
          shift_d  = 6'h00;
          if (m_smem && long_addr(word_i[7:0])) begin
            words_d  = 3'(m_len + 2'h1);
            cycles_d = 3'(m_cyc + 2'h1);
          end
          unique case (m_op)
            daod_pkg::OP_ADD_SMEM_SHIFT: begin
              valid_d = 1'b0;
              state_d = daod_pkg::ST_SECOND;
            end
            daod_pkg::OP_ADD_XMEM_FOUR_BIT_SHIFT_FIELD: shift_d = sx4(word_i[3:0]);
            daod_pkg::OP_ADD_LK_FOUR_BIT_SHIFT_FIELD: shift_d = sx4(word_i[3:0]);
            daod_pkg::OP_ADD_LK_16,
            daod_pkg::OP_ADD_SMEM_16,
            daod_pkg::OP_ADD_DUAL: shift_d = 6'h10;
            daod_pkg::OP_ADD_ACC_SHIFT: shift_d = word_i[4:0] > 5'h0f ?
              {1'b1, word_i[4:0]} : {1'b0, word_i[4:0]};
            default: shift_d = 6'h00;
          endcase
          if (m_op != daod_pkg::OP_ADD_SMEM_SHIFT) begin
            valid_d = 1'b1;
            ill_d   = (m_op == daod_pkg::OP_NONE);
            if (m_len == daod_pkg::LEN_TWO ||
                (m_smem && long_addr(word_i[7:0]))) begin
              skip_d  = 2'(words_d - 3'h1);
              state_d = daod_pkg::ST_SKIP;
            end
          end
        end
        daod_pkg::ST_SECOND: begin
          if (word_i[15:10] == daod_pkg::SECOND_PREFIX &&
              word_i[7:5] == 3'h0) begin
            src_d   = word_i[9];
            dst_d   = word_i[8];
            shift_d = {word_i[4], word_i[4], word_i[3:0]};
          end else begin
            ill_d = 1'b1;
          end
          valid_d = 1'b1;
          if (long_addr(first_q[7:0])) begin
            skip_d  = 2'h1;
            state_d = daod_pkg::ST_SKIP;
          end else begin
            state_d = daod_pkg::ST_FIRST;
          end
        end
        daod_pkg::ST_SKIP: begin
          skip_d = skip_q - 2'h1;
          if (skip_q == 2'h1) state_d = daod_pkg::ST_FIRST;
        end
        default: state_d = daod_pkg::ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q  <= daod_pkg::ST_FIRST;
      first_q  <= 16'h0000;
      op_q     <= 5'h00;
      words_q  <= 3'h0;
      cycles_q <= 3'h0;
      src_q    <= 1'b0;
      dst_q    <= 1'b0;
      addr_q   <= 8'h00;
      xmem_q   <= 4'h0;
      ymem_q   <= 4'h0;
      shift_q  <= 6'h00;
      valid_q  <= 1'b0;
      ill_q    <= 1'b0;
      skip_q   <= 2'h0;
    end else if (clk_en_i) begin
      state_q  <= state_d;
      first_q  <= first_d;
      op_q     <= op_d;
      words_q  <= words_d;
      cycles_q <= cycles_d;
      src_q    <= src_d;
      dst_q    <= dst_d;
      addr_q   <= addr_d;
      xmem_q   <= xmem_d;
      ymem_q   <= ymem_d;
      shift_q  <= shift_d;
      valid_q  <= valid_d;
      ill_q    <= ill_d;
      skip_q   <= skip_d;
    end
  end

  assign dec_valid_o = valid_q;
  assign op_o        = op_q;
  assign words_o     = words_q;
  assign cycles_o    = cycles_q;
  assign src_o       = src_q;
  assign dst_o       = dst_q;
  assign addr_o      = addr_q;
  assign xmem_o      = xmem_q;
  assign ymem_o      = ymem_q;
  assign shift_o     = shift_q;
  assign illegal_o   = ill_q;

endmodule // daod_decoder

//--- design/daod_pkg.sv
// Constants and types for the arithmetic opcode decoder.
// Assumes a 16-bit instruction word and a single core clock.
package daod_pkg;

  localparam int WORD_W = 16;

  // Decoded operation identifiers.
  typedef enum logic [4:0] {
    OP_NONE             = 5'h00,
    OP_ABS_DIST         = 5'h01,
    OP_ACC_ABS_VALUE    = 5'h02,
    OP_ADD_SMEM         = 5'h03,
    OP_ADD_SMEM_TS      = 5'h04,
    OP_ADD_SMEM_16      = 5'h05,
    OP_ADD_SMEM_SHIFT   = 5'h06,
    OP_ADD_XMEM_FOUR_BIT_SHIFT_FIELD    = 5'h07,
    OP_ADD_DUAL         = 5'h08,
    OP_ADD_LK_FOUR_BIT_SHIFT_FIELD      = 5'h09,
    OP_ADD_LK_16        = 5'h0a,
    OP_ADD_ACC_SHIFT    = 5'h0b,
    OP_ADD_ACC_ASM      = 5'h0c,
    OP_ADD_WITH_CARRY   = 5'h0d,
    OP_ADD_IMM_TO_MEM   = 5'h0e,
    OP_ADD_NO_SIGN_EXT  = 5'h0f,
    OP_LONG_ADD         = 5'h10,
    OP_LONG_ADD_SUB_T   = 5'h11,
    OP_MEM_DELAY        = 5'h12,
    OP_LONG_REV_SUB     = 5'h13,
    OP_LONG_SUB_ADD_T   = 5'h14,
    OP_LONG_SUB         = 5'h15
  } daod_op_t;

  // Decoder pipeline states.
  typedef enum logic [1:0] {
    ST_FIRST  = 2'h0,
    ST_SECOND = 2'h1,
    ST_SKIP   = 2'h2
  } daod_state_t;

  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;

  // Addressing field: bit 7 selects indirect, bits 6:3 the indirect mode.
  localparam int         ADDR_IND_BIT = 7;
  localparam logic [3:0] MOD_LONG_OFS = 4'hc;
  localparam logic [3:0] MOD_ABS      = 4'hf;

  // Second-word prefix, bits 15:10, of the two-word shifted add.
  localparam logic [5:0] SECOND_PREFIX = 6'h03;

endpackage : daod_pkg

//--- design/daod_match.sv
// Pure first-word classifier for the arithmetic opcode group.
// Assumes a 16-bit first word; no clock, no state.
`timescale 1ns/1ps
module daod_match (
  input  wire logic [15:0]       word_i,
  output daod_pkg::daod_op_t     op_o,
  output logic [1:0]             len_o,
  output logic [1:0]             cyc_o,
  output logic                   smem_o
);

  logic [3:0] n3;
  logic [3:0] n2;
  logic [3:0] n1;
  logic [3:0] n0;

  assign n3 = word_i[15:12];
  assign n2 = word_i[11:8];
  assign n1 = word_i[7:4];
  assign n0 = word_i[3:0];

  always_comb begin
    op_o   = daod_pkg::OP_NONE;
    len_o  = daod_pkg::LEN_ONE;
    cyc_o  = daod_pkg::CYC_ONE;
    smem_o = 1'b0;
    unique case (n3)
      4'h0: begin
        smem_o = 1'b1;
        unique case (n2[3:1])
          3'h0: op_o = daod_pkg::OP_ADD_SMEM;
          3'h1: op_o = daod_pkg::OP_ADD_NO_SIGN_EXT;
          3'h2: op_o = daod_pkg::OP_ADD_SMEM_TS;
          3'h3: op_o = daod_pkg::OP_ADD_WITH_CARRY;
          default: smem_o = 1'b0;
        endcase
      end
      4'h3: begin
        if (n2[3:2] == 2'h3) begin
          op_o   = daod_pkg::OP_ADD_SMEM_16;
          smem_o = 1'b1;
        end
      end
      4'h4: begin
        if (n2 == 4'hd) begin
          op_o   = daod_pkg::OP_MEM_DELAY;
          smem_o = 1'b1;
        end
      end
      4'h5: begin
        unique case (n2[3:1])
          3'h0, 3'h1: op_o = daod_pkg::OP_LONG_ADD;
          3'h2: op_o = daod_pkg::OP_LONG_SUB;
          3'h4: op_o = daod_pkg::OP_LONG_REV_SUB;
          3'h5: op_o = daod_pkg::OP_LONG_ADD_SUB_T;
          3'h7: op_o = daod_pkg::OP_LONG_SUB_ADD_T;
          default: op_o = daod_pkg::OP_NONE;
        endcase
      end
      4'h6: begin
        if (n2 == 4'hf || n2 == 4'hb) begin
          op_o   = (n2 == 4'hf) ? daod_pkg::OP_ADD_SMEM_SHIFT
                                : daod_pkg::OP_ADD_IMM_TO_MEM;
          len_o  = daod_pkg::LEN_TWO;
          cyc_o  = daod_pkg::CYC_TWO;
          smem_o = 1'b1;
        end
      end
      4'h9: begin
        if (n2[3:1] == 3'h0) op_o = daod_pkg::OP_ADD_XMEM_FOUR_BIT_SHIFT_FIELD;
      end
      4'ha: begin
        if (n2[3:1] == 3'h0) op_o = daod_pkg::OP_ADD_DUAL;
      end
      4'he: begin
        if (n2 == 4'h3) op_o = daod_pkg::OP_ABS_DIST;
      end
      4'hf: begin
        if (n2[3:2] == 2'h0 && n1 == 4'h0) begin
          op_o  = daod_pkg::OP_ADD_LK_FOUR_BIT_SHIFT_FIELD;
          len_o = daod_pkg::LEN_TWO;
          cyc_o = daod_pkg::CYC_TWO;
        end else if (n2[3:2] == 2'h0 && n1 == 4'h6 && n0 == 4'h0) begin
          op_o  = daod_pkg::OP_ADD_LK_16;
          len_o = daod_pkg::LEN_TWO;
          cyc_o = daod_pkg::CYC_TWO;
        end else if (n2[3:2] == 2'h1 && n1[3:1] == 3'h0) begin
          op_o = daod_pkg::OP_ADD_ACC_SHIFT;
        end else if (n2[3:2] == 2'h1 && n1 == 4'h8 && n0 == 4'h0) begin
          op_o = daod_pkg::OP_ADD_ACC_ASM;
        end else if (n2[3:2] == 2'h1 && n1 == 4'h8 && n0 == 4'h5) begin
          op_o = daod_pkg::OP_ACC_ABS_VALUE;
        end
      end
      default: op_o = daod_pkg::OP_NONE;
    endcase
  end

endmodule // daod_match

//--- verif/daod_sva.sv
// Port checker for the arithmetic opcode decoder.
// Assumes the ports of daod_decoder and one core clock.
`timescale 1ns/1ps
module daod_sva (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        clk_en_i,
  input wire logic        word_valid_i,
  input wire logic [15:0] word_i,
  input wire logic        dec_valid_o,
  input wire logic [4:0]  op_o,
  input wire logic [2:0]  words_o,
  input wire logic [2:0]  cycles_o,
  input wire logic        src_o,
  input wire logic        dst_o,
  input wire logic [7:0]  addr_o,
  input wire logic [3:0]  xmem_o,
  input wire logic [3:0]  ymem_o,
  input wire logic [5:0]  shift_o,
  input wire logic        illegal_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic ok;
  logic lng;
  logic en_q;
  // Remembers whether the last edge was enabled, so held results are not
  // mistaken for fresh ones.
  always_ff @(posedge ref_clk_i) en_q <= clk_en_i;
  assign ok = dec_valid_o && !illegal_o && en_q;
  assign lng = addr_o[7] && (addr_o[6:3] == daod_pkg::MOD_LONG_OFS ||
    addr_o[6:3] == daod_pkg::MOD_ABS);
  abs_len_a: assert property (
    ok && op_o == daod_pkg::OP_ACC_ABS_VALUE |->
    words_o == 3'h1 && cycles_o == 3'h1 && $past(word_i[7:0]) == 8'h85)
    else $error("abs decode wrong");
  shift_sixteen_a: assert property (
    ok && op_o == daod_pkg::OP_ADD_SMEM_16 |-> shift_o == 6'h10)
    else $error("by-sixteen shift wrong");
  long_imm_a: assert property (
    ok && op_o inside {daod_pkg::OP_ADD_LK_FOUR_BIT_SHIFT_FIELD, daod_pkg::OP_ADD_LK_16}
    |-> words_o == 3'h2 && cycles_o == 3'h2)
    else $error("long immediate length wrong");
  acc_shift_a: assert property (
    ok && op_o == daod_pkg::OP_ADD_ACC_SHIFT |->
    shift_o == {$past(word_i[4]), $past(word_i[4:0])})
    else $error("accumulator shift wrong");
  sd_fields_a: assert property (
    ok && op_o == daod_pkg::OP_LONG_ADD |->
    src_o == $past(word_i[9]) && dst_o == $past(word_i[8]))
    else $error("source or destination bit wrong");
  long_addr_a: assert property (
    ok && op_o == daod_pkg::OP_ADD_WITH_CARRY |->
    words_o == (lng ? 3'h2 : 3'h1) && cycles_o == words_o)
    else $error("long addressing count wrong");
  dual_fields_a: assert property (
    ok && op_o == daod_pkg::OP_ADD_DUAL |->
    xmem_o == $past(word_i[7:4]) && ymem_o == $past(word_i[3:0]))
    else $error("dual operand fields wrong");
  taken_word_a: assert property (
    dec_valid_o && en_q |-> $past(word_valid_i))
    else $error("decode without word");
  frozen_hold_a: assert property (
    !en_q |-> $stable(dec_valid_o) && $stable(op_o) && $stable(shift_o))
    else $error("state moved while frozen");
  illegal_pulse_a: assert property (illegal_o |-> dec_valid_o)
    else $error("illegal without valid");
  cover property (ok && op_o == daod_pkg::OP_ADD_SMEM_SHIFT);
  cover property (illegal_o);
  cover property (ok && lng);
endmodule // daod_sva
bind daod_decoder daod_sva u_sva (.ref_clk_i, .arst_n_i, .clk_en_i,
  .word_valid_i, .word_i, .dec_valid_o, .op_o, .words_o, .cycles_o, .src_o,
  .dst_o, .addr_o, .xmem_o, .ymem_o, .shift_o, .illegal_o);

//--- verif/daod_fetch_model.sv
// Fetch stage model: presents one word per requested cycle.
// Assumes requests change at the rising edge; drives at the falling edge.
`timescale 1ns/1ps
module daod_fetch_model (
  input  wire logic        ref_clk_i,
  input  wire logic        req_i,
  input  wire logic [15:0] req_word_i,
  output logic             word_valid_o,
  output logic [15:0]      word_o
);
  initial begin
    word_valid_o = 1'b0;
    word_o = 16'h0;
  end
  // Idle cycles invert the previous word each cycle, so every second idle cycle shows the last word again.
  always @(negedge ref_clk_i) begin
    word_valid_o <= req_i;
    word_o <= req_i ? req_word_i : ~word_o;
  end
endmodule // daod_fetch_model

//--- verif/tb.sv
// Self-checking bench for the arithmetic opcode decoder.
// Assumes daod_decoder, daod_fetch_model and a 40 MHz core clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  logic        ref_clk_i, arst_n_i, clk_en_i, req, wv, dv, src, dst, ill;
  logic [15:0] rw, w;
  logic [4:0]  op;
  logic [2:0]  wds, cyc;
  logic [7:0]  addr;
  logic [3:0]  xm, ym;
  logic [5:0]  sh;
  logic [11:0] q[$];
  int          err_count, checked, cnt;
  daod_fetch_model fm (.ref_clk_i(ref_clk_i), .req_i(req),
    .req_word_i(rw), .word_valid_o(wv), .word_o(w));
  daod_decoder dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i), .word_valid_i(wv), .word_i(w), .dec_valid_o(dv),
    .op_o(op), .words_o(wds), .cycles_o(cyc), .src_o(src), .dst_o(dst),
    .addr_o(addr), .xmem_o(xm), .ymem_o(ym), .shift_o(sh),
    .illegal_o(ill));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) if (dv === 1'b1) q.push_back({ill, op, wds, cyc});
  always @(posedge ref_clk_i) begin
    cnt++;
    if (cnt > 2000) begin
      err_count++;
      report_and_stop();
    end
  end
  task push(input logic [15:0] x);
    @(posedge ref_clk_i);
    req <= 1'b1;
    rw <= x;
  endtask
  task idle(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      req <= 1'b0;
    end
    @(negedge ref_clk_i);
  endtask
  task pop(output logic [11:0] v);
    v = q.size() ? q.pop_front() : 12'hfff;
  endtask
  task dec(input logic [4:0] e_op, input logic [2:0] n);
    logic [11:0] v;
    pop(v);
    `CHK("decode", {1'b0, e_op, n, n}, v)
  endtask
  task automatic t_one_word;
    logic [15:0] wt[17] = '{16'hf585, 16'h0412, 16'h3f12, 16'ha123,
      16'hf51a, 16'hf580, 16'h0612, 16'h0212, 16'h5012, 16'h5a12,
      16'h5812, 16'h5e12, 16'h5412, 16'h0012, 16'h9107, 16'he312,
      16'h4d12};
    logic [4:0] ot[17] = '{daod_pkg::OP_ACC_ABS_VALUE,
      daod_pkg::OP_ADD_SMEM_TS, daod_pkg::OP_ADD_SMEM_16,
      daod_pkg::OP_ADD_DUAL, daod_pkg::OP_ADD_ACC_SHIFT,
      daod_pkg::OP_ADD_ACC_ASM, daod_pkg::OP_ADD_WITH_CARRY,
      daod_pkg::OP_ADD_NO_SIGN_EXT, daod_pkg::OP_LONG_ADD,
      daod_pkg::OP_LONG_ADD_SUB_T, daod_pkg::OP_LONG_REV_SUB,
      daod_pkg::OP_LONG_SUB_ADD_T, daod_pkg::OP_LONG_SUB,
      daod_pkg::OP_ADD_SMEM, daod_pkg::OP_ADD_XMEM_FOUR_BIT_SHIFT_FIELD,
      daod_pkg::OP_ABS_DIST, daod_pkg::OP_MEM_DELAY};
    foreach (wt[i]) push(wt[i]);
    idle(3);
    foreach (ot[i]) dec(ot[i], 3'h1);
    $display("one-word table done");
  endtask
  task t_fields;
    push(16'hf51a);
    idle(2);
    `CHK("shift", 6'h3a, sh)
    `CHK("sd", 2'h1, {src, dst})
    push(16'h3f12);
    idle(2);
    `CHK("sh16", 14'h1012, {sh, addr})
    push(16'ha123);
    idle(2);
    `CHK("xy", 8'h23, {xm, ym})
    q.delete();
    $display("field test done");
  endtask
  task t_two_word;
    logic [11:0] v;
    push(16'h6f12);
    push(16'h0f1a);
    idle(2);
    dec(daod_pkg::OP_ADD_SMEM_SHIFT, 3'h2);
    `CHK("fields", 16'heb12, {sh, src, dst, addr})
    push(16'h6f12);
    push(16'h4d1a);
    push(16'hf585);
    idle(3);
    pop(v);
    `CHK("illegal", 1'b1, v[11])
    dec(daod_pkg::OP_ACC_ABS_VALUE, 3'h1);
    push(16'h7000);
    idle(2);
    pop(v);
    `CHK("foreign", 12'h809, v)
    $display("two-word add done");
  endtask
  task t_long;
    push(16'hf30c);
    push(16'haaaa);
    push(16'hf060);
    push(16'h1234);
    push(16'h6b12);
    push(16'hf585);
    push(16'h06f8);
    push(16'h5555);
    push(16'h02e0);
    push(16'hf585);
    push(16'hf585);
    idle(3);
    dec(daod_pkg::OP_ADD_LK_FOUR_BIT_SHIFT_FIELD, 3'h2);
    dec(daod_pkg::OP_ADD_LK_16, 3'h2);
    dec(daod_pkg::OP_ADD_IMM_TO_MEM, 3'h2);
    dec(daod_pkg::OP_ADD_WITH_CARRY, 3'h2);
    dec(daod_pkg::OP_ADD_NO_SIGN_EXT, 3'h2);
    dec(daod_pkg::OP_ACC_ABS_VALUE, 3'h1);
    `CHK("left", 0, q.size())
    $display("long forms done");
  endtask
  task t_freeze;
    clk_en_i = 1'b0;
    push(16'hf585);
    idle(2);
    clk_en_i = 1'b1;
    idle(2);
    `CHK("frozen", 0, q.size())
    $display("freeze test done");
  endtask
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    arst_n_i = 1'b0;
    clk_en_i = 1'b1;
    req = 1'b0;
    rw = 16'h0;
    repeat (5) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    t_one_word();
    t_fields();
    t_two_word();
    t_long();
    t_freeze();
    report_and_stop();
  end
endmodule // tb
